// file: src/dtp_params.svh
`ifndef DTP_PARAMS_SVH
`define DTP_PARAMS_SVH
// register byte offsets
`define DTP_OFS_CTRL      4'h0
`define DTP_OFS_THRESH    4'h4
`define DTP_OFS_STATUS    4'h8
`define DTP_OFS_READOUT   4'hC
// control fields
`define DTP_CTRL_MOD      0
`define DTP_CTRL_DROP     1
`define DTP_CTRL_FORCE    2
`define DTP_CTRL_IE_RISE  3
`define DTP_CTRL_IE_FALL  4
`define DTP_CTRL_IE_THR1  5
`define DTP_CTRL_IE_THR2  6
`define DTP_CTRL_IE_OOS   7
`define DTP_CTRL_RST      8'h03
// threshold fields
`define DTP_THR1_LSB      0
`define DTP_THR2_LSB      8
`define DTP_THR_RST       16'h0000
// status fields: sticky events in [4:0], live state above
`define DTP_EV_RISE       0
`define DTP_EV_FALL       1
`define DTP_EV_THR1       2
`define DTP_EV_THR2       3
`define DTP_EV_OOS        4
`define DTP_ST_HOT        8
`define DTP_ST_ENGINE     9
`define DTP_ST_OOS        10
`define DTP_ST_EXT        11
`define DTP_ST_TRIP       12
// readout fields
`define DTP_RD_VALID      8
// timing in core clock cycles
`define DTP_MOD_HALF_CYC  16
`define DTP_FORCE_WAIT    64
`define DTP_OOS_WAIT      256
`endif

// file: src/dtp_pkg.sv
package dtp_pkg;
    typedef enum logic [2:0] {CS_C0, CS_C1, CS_C2, CS_C4, CS_C6} dtp_core_t;
    typedef enum logic [1:0] {TH_IDLE, TH_MOD, TH_DROP, TH_DROP_MOD} dtp_throttle_t;
endpackage : dtp_pkg

// file: src/dtp_thermal.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtp_params.svh"
// Operation
// [R1] drive the hot pin while die temperature is above the trip point
// [R2] optional interrupt on hot assertion and on hot deassertion
// [R3] no new hot assertion in sleep, deep sleep or deeper sleep
// [R4] hot held through low power until exit and temperature below trip
// [R5] catastrophic trip asserted at catastrophic temperature, any mode, no bus cycles
// [R6] core hot input and output only in C0 to C2; north complex always
// [R7] core trip active C0 to C2, off in C6; north complex always
// [R8] readout is offset below maximum, never above the maximum
// [R9] readout valid only in normal package state
// [R10] throttled and still hot: out-of-spec bit, sticky copy, interrupt
// [R11] readout at maximum activates the enabled throttle mechanism
// [R12] two programmable thresholds, each can interrupt on crossing
// [R13] trip halts every internal clock and activity
// [R14] platform removes core supply within 500 ms after trip
// [R15] trip only relied upon while supply good is asserted
// [R16] mode enabled and hot asserted keeps throttle engine active
// [R17] external drive of hot pin activates throttle engine
// [R18] internal trip: modulation alone modulates, drop selects lowest state
// [R19] external hot: modulation only if drop disabled, force ignored
// [R20] external monitor pulls hot pin low while its limit exceeded
// [R21] events keep latching while the throttle engine is active
// [R22] modulation alternates clocks at half on, half off
// [R23] both enabled: drop wins, modulation added if forced and drop fails
// [R24] external hot input passes a two-stage synchronizer
module dtp_thermal #(
    parameter int          TEMP_W       = 8,
    parameter logic [7:0]  TJ_MAX       = 8'h5A,
    parameter logic [7:0]  CAT_TEMP     = 8'h7D,
    parameter logic [7:0]  HYST         = 8'h02,
    parameter int          MOD_HALF_CYC = `DTP_MOD_HALF_CYC,
    parameter int          FORCE_WAIT   = `DTP_FORCE_WAIT,
    parameter int          OOS_WAIT     = `DTP_OOS_WAIT
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // sensor and power state
    input  wire logic [TEMP_W-1:0] die_temp_i,
    input  wire logic [2:0]        core_state_i,
    input  wire logic              sleep_state_i,
    input  wire logic              pkg_low_power_i,
    input  wire logic              supply_good_i,
    // open-drain hot pin
    input  wire logic              thermal_hot_n_i,
    output logic                   thermal_hot_n_o,
    output logic                   thermal_hot_n_oe_o,
    output logic                   nc_thermal_hot_o,
    // catastrophic trip
    output logic                   catastrophic_trip_n_o,
    output logic                   nc_catastrophic_trip_n_o,
    output logic                   halt_clocks_o,
    // throttle engine
    output logic                   engine_active_o,
    output logic                   core_clk_en_o,
    output logic                   perf_drop_o,
    output logic                   thermal_irq_o
);
    typedef struct packed {
        logic [7:0]            ctrl;
        logic [15:0]           thr;
        logic [4:0]            ev;
        logic [1:0]            above;
        logic                  die_hot;
        logic                  drv;
        logic                  drv_p;
        logic                  drv_pp;
        logic                  s1;
        logic                  s2;
        logic                  ext;
        logic                  hot_pin;
        logic                  trip;
        logic                  nc_trip;
        logic                  oos;
        dtp_pkg::dtp_throttle_t th;
        logic [15:0]           mod_cnt;
        logic                  mod_on;
        logic [15:0]           force_cnt;
        logic [15:0]           oos_cnt;
        logic [7:0]            rel;
        logic                  valid;
        logic                  ack;
        logic [31:0]           rdat;
        logic                  irq;
        logic                  eng;
        logic                  pdrop;
        logic                  clk_en;
    } dtp_state_t;

    dtp_state_t q, d;
    dtp_pkg::dtp_core_t cs;
    logic              wr;
    logic              rd;
    logic [7:0]        trip_lvl;
    logic [1:0]        above_now;
    logic              core_ok;
    logic              drop_en;
    logic              mod_en;
    logic              hot_any;

    localparam logic [15:0] MOD_HALF = 16'(MOD_HALF_CYC);
    localparam logic [15:0] FORCE_W  = 16'(FORCE_WAIT);
    localparam logic [15:0] OOS_W    = 16'(OOS_WAIT);

    assign cs = dtp_pkg::dtp_core_t'(core_state_i);

    // ************************************************************
    // threshold crossing
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_thr
            assign above_now[gi] = q.rel <= q.thr[gi*8 +: 8]; // [R12]
        end
    endgenerate

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d        = q;
        wr       = wb_cyc_i && wb_stb_i && !q.ack && wb_we_i && wb_sel_i[0];
        rd       = wb_cyc_i && wb_stb_i && !q.ack;
        trip_lvl = TJ_MAX - HYST;
        core_ok  = (cs == dtp_pkg::CS_C0) || (cs == dtp_pkg::CS_C1) || (cs == dtp_pkg::CS_C2);
        mod_en   = q.ctrl[`DTP_CTRL_MOD];
        drop_en  = q.ctrl[`DTP_CTRL_DROP];
        hot_any  = q.die_hot || q.ext;
        // bus slave answers one cycle after the request
        d.ack    = rd;
        if (rd) begin
            case (wb_adr_i)
                `DTP_OFS_CTRL:    d.rdat = {24'h000000, q.ctrl};
                `DTP_OFS_THRESH:  d.rdat = {16'h0000, q.thr};
                `DTP_OFS_STATUS:  d.rdat = {19'h00000, q.trip, q.ext, q.oos,
                                            q.th != dtp_pkg::TH_IDLE, q.hot_pin, 3'h0, q.ev};
                `DTP_OFS_READOUT: d.rdat = {23'h000000, q.valid, q.rel};
                default:          d.rdat = 32'h00000000;
            endcase
        end
        if (wr && wb_adr_i == `DTP_OFS_CTRL) begin
            d.ctrl = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == `DTP_OFS_THRESH) begin
            d.thr[7:0] = wb_dat_i[7:0];
        end
        if (wb_cyc_i && wb_stb_i && !q.ack && wb_we_i && wb_sel_i[1] && wb_adr_i == `DTP_OFS_THRESH) begin
            d.thr[15:8] = wb_dat_i[15:8];
        end
        // sticky events: write one to clear, a new event wins
        if (wr && wb_adr_i == `DTP_OFS_STATUS) begin
            d.ev = q.ev & ~wb_dat_i[4:0];
        end
        // readout relative to maximum, saturated at zero
        d.rel   = (die_temp_i >= TJ_MAX) ? 8'h00 : 8'(TJ_MAX - die_temp_i); // [R8]
        d.valid = !pkg_low_power_i; // [R9]
        // die trip point with hysteresis
        if (d.rel == 8'h00) begin
            d.die_hot = 1'b1; // [R11]
        end else if (die_temp_i < trip_lvl) begin
            d.die_hot = 1'b0;
        end
        // pin drive
        if (sleep_state_i) begin
            d.drv = q.drv; // [R3] [R4]
        end else begin
            d.drv = q.die_hot && core_ok; // [R1] [R6]
        end
        d.drv_p  = q.drv;
        d.drv_pp = q.drv_p;
        // external hot: pin low while this end was not pulling it
        // the synchroniser still shows our own drive for two cycles after release
        d.s1  = thermal_hot_n_i;
        d.s2  = q.s1; // [R24]
        d.ext = !q.s2 && !q.drv && !q.drv_p && !q.drv_pp && core_ok; // [R17] [R6] [R20]
        d.hot_pin = q.drv || q.ext;
        // throttle selection
        d.th = dtp_pkg::TH_IDLE;
        if (q.die_hot && (mod_en || drop_en)) begin // [R16]
            if (drop_en && mod_en && q.ctrl[`DTP_CTRL_FORCE] && q.force_cnt >= FORCE_W) begin
                d.th = dtp_pkg::TH_DROP_MOD; // [R23]
            end else if (drop_en) begin
                d.th = dtp_pkg::TH_DROP; // [R18]
            end else begin
                d.th = dtp_pkg::TH_MOD; // [R18]
            end
        end else if (q.ext && (mod_en || drop_en)) begin // [R17]
            d.th = drop_en ? dtp_pkg::TH_DROP : dtp_pkg::TH_MOD; // [R19]
        end
        d.eng   = d.th != dtp_pkg::TH_IDLE; // [R16]
        d.pdrop = d.th == dtp_pkg::TH_DROP || d.th == dtp_pkg::TH_DROP_MOD; // [R18]
        d.force_cnt = (q.th == dtp_pkg::TH_DROP && q.die_hot && q.force_cnt < FORCE_W) ?
                      q.force_cnt + 16'h0001 : (q.die_hot ? q.force_cnt : 16'h0000);
        // clock modulation half on, half off
        if (q.th == dtp_pkg::TH_MOD || q.th == dtp_pkg::TH_DROP_MOD) begin
            if (q.mod_cnt >= MOD_HALF - 16'h0001) begin
                d.mod_cnt = 16'h0000;
                d.mod_on  = !q.mod_on; // [R22]
            end else begin
                d.mod_cnt = q.mod_cnt + 16'h0001;
            end
        end else begin
            d.mod_cnt = 16'h0000;
            d.mod_on  = 1'b1;
        end
        // out of specification
        if (q.th != dtp_pkg::TH_IDLE && q.die_hot) begin
            d.oos_cnt = (q.oos_cnt < OOS_W) ? q.oos_cnt + 16'h0001 : q.oos_cnt;
        end else begin
            d.oos_cnt = 16'h0000;
        end
        d.oos = (q.oos_cnt >= OOS_W); // [R10]
        // event latching continues while throttled
        d.above = above_now;
        d.ev[`DTP_EV_OOS]  = d.ev[`DTP_EV_OOS]  | (d.oos && !q.oos); // [R10] [R21]
        d.ev[`DTP_EV_RISE] = d.ev[`DTP_EV_RISE] | (d.hot_pin && !q.hot_pin); // [R2]
        d.ev[`DTP_EV_FALL] = d.ev[`DTP_EV_FALL] | (!d.hot_pin && q.hot_pin); // [R2]
        d.ev[`DTP_EV_THR1] = d.ev[`DTP_EV_THR1] | (above_now[0] != q.above[0]); // [R12]
        d.ev[`DTP_EV_THR2] = d.ev[`DTP_EV_THR2] | (above_now[1] != q.above[1]); // [R12]
        d.irq = |(q.ev & q.ctrl[7:3]);
        // catastrophic trip, latched until reset; C4 kept active though not guaranteed
        if (supply_good_i && die_temp_i >= CAT_TEMP) begin // [R15]
            d.nc_trip = 1'b1; // [R7]
            if (cs != dtp_pkg::CS_C6) begin
                d.trip = 1'b1; // [R5] [R7]
            end
        end
        // a tripped die freezes everything else, bus included
        if (q.trip) begin
            d      = q; // [R13]
            d.ack  = 1'b0;
            d.trip = 1'b1;
            d.nc_trip = 1'b1;
        end
        d.clk_en = d.mod_on && !d.trip; // [R13]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q       <= '0;
            q.ctrl  <= `DTP_CTRL_RST;
            q.thr   <= `DTP_THR_RST;
            q.s1    <= 1'b1;
            q.s2    <= 1'b1;
            q.mod_on <= 1'b1;
            q.clk_en <= 1'b1;
            q.th    <= dtp_pkg::TH_IDLE;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_dat_o                 = q.rdat;
    assign wb_ack_o                 = q.ack;
    assign thermal_hot_n_o          = 1'b0;
    assign thermal_hot_n_oe_o       = q.drv;
    assign nc_thermal_hot_o         = q.die_hot;
    assign catastrophic_trip_n_o    = !q.trip;
    assign nc_catastrophic_trip_n_o = !q.nc_trip;
    assign halt_clocks_o            = q.trip;
    assign engine_active_o          = q.eng;
    assign core_clk_en_o            = q.clk_en;
    assign perf_drop_o              = q.pdrop;
    assign thermal_irq_o            = q.irq;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ************************************************************
    // readout and bus checks
    // ************************************************************
    a_bus_frozen: assert property (q.trip |=> !wb_ack_o) // [R13]
        else $error("bus answered after trip");
    a_readout_valid: assert property (!q.trip |=> q.valid == !$past(pkg_low_power_i)) // [R9]
        else $error("readout valid in package low power");
    a_readout_max: assert property (die_temp_i >= TJ_MAX && !q.trip |=> q.rel == 8'h00 && q.die_hot) // [R11]
        else $error("maximum reached without hot");
    a_readout_offs: assert property (die_temp_i < TJ_MAX && !q.trip |=> q.rel == 8'(TJ_MAX - $past(die_temp_i))) // [R8]
        else $error("readout offset wrong");

    // ************************************************************
    // hot pin checks
    // ************************************************************
    a_core_quiet: assert property (!core_ok && !sleep_state_i && !q.trip |=> !q.drv) // [R6]
        else $error("hot driven in deep core state");
    a_ext_core: assert property (!core_ok && !q.trip |=> !q.ext) // [R6]
        else $error("external hot taken in deep core state");
    a_hold_exit: assert property (!sleep_state_i && !q.die_hot && !q.trip |=> !q.drv) // [R4]
        else $error("hot held after cooling");
    a_ext_mask: assert property (q.drv && !q.trip |=> !q.ext) // [R24]
        else $error("own drive seen as external hot");

    a_hot_drive: assert property (!sleep_state_i && !q.trip && q.die_hot && core_ok |=> q.drv) // [R1]
        else $error("hot pin not driven while die hot");
    a_sleep_nonew: assert property (sleep_state_i && !q.drv && !q.trip |=> !q.drv) // [R3]
        else $error("hot newly asserted in sleep");
    a_sleep_hold: assert property (sleep_state_i && q.drv && !q.trip |=> q.drv) // [R4]
        else $error("hot released in sleep");
    a_trip_latch: assert property (q.trip |=> q.trip && !catastrophic_trip_n_o && halt_clocks_o) // [R5]
        else $error("trip not held");
    a_trip_c6: assert property (!q.trip && cs == dtp_pkg::CS_C6 |=> !q.trip) // [R7]
        else $error("core trip in C6");
    a_trip_sg: assert property (!q.nc_trip && !supply_good_i |=> !q.nc_trip) // [R15]
        else $error("trip without supply good");
    a_rel_sat: assert property (q.rel <= TJ_MAX) // [R8]
        else $error("readout above maximum");
    a_engine_hot: assert property (q.die_hot && (mod_en || drop_en) && !q.trip |=> engine_active_o) // [R16]
        else $error("engine idle while hot");
    a_ext_drop: assert property (q.ext && !q.die_hot && drop_en && !q.trip |=> perf_drop_o && core_clk_en_o) // [R19]
        else $error("external hot did not drop alone");
    a_mod_duty: assert property (q.th == dtp_pkg::TH_MOD && $rose(q.mod_on) && !q.trip
        ##1 (q.th == dtp_pkg::TH_MOD && !q.trip) [*4] |-> q.mod_on) // [R22]
        else $error("modulation period too short");
    a_sync_ext: assert property ($fell(thermal_hot_n_i) ##1 1'b1 |-> !q.ext) // [R24]
        else $error("external hot not synchronised");
    a_oos_sticky: assert property ($rose(q.oos) && !q.trip |=> q.ev[`DTP_EV_OOS]) // [R10]
        else $error("out-of-spec not latched");


    // ************************************************************
    // trip and throttle checks
    // ************************************************************
    a_trip_cat: assert property (supply_good_i && die_temp_i >= CAT_TEMP && cs != dtp_pkg::CS_C6 |=> q.trip) // [R5]
        else $error("core trip missed");
    a_trip_c4: assert property (supply_good_i && die_temp_i >= CAT_TEMP && cs == dtp_pkg::CS_C4 |=> q.trip) // [R7]
        else $error("core trip missed in C4");
    a_nc_trip: assert property (supply_good_i && die_temp_i >= CAT_TEMP |=> q.nc_trip) // [R7]
        else $error("north complex trip missed");
    a_trip_clk: assert property (q.trip |-> !core_clk_en_o) // [R13]
        else $error("clock running after trip");
    a_engine_any: assert property (hot_any && (mod_en || drop_en) && !q.trip |=> engine_active_o) // [R17]
        else $error("engine idle while hot");
    a_ext_mod: assert property (q.ext && !q.die_hot && mod_en && !drop_en && !q.trip
        |=> engine_active_o && !perf_drop_o) // [R19]
        else $error("external hot did not modulate");
    a_drop_first: assert property (q.die_hot && drop_en && !q.ctrl[`DTP_CTRL_FORCE] && !q.trip |=> perf_drop_o) // [R18]
        else $error("drop not selected");
    a_force_add: assert property (q.die_hot && drop_en && mod_en && q.ctrl[`DTP_CTRL_FORCE]
        && q.force_cnt >= FORCE_W && !q.trip |=> q.th == dtp_pkg::TH_DROP_MOD) // [R23]
        else $error("forced modulation not added");
    a_rise_event: assert property ($rose(q.hot_pin) |-> q.ev[`DTP_EV_RISE]) // [R2]
        else $error("rise event lost");
    a_fall_event: assert property ($fell(q.hot_pin) |-> q.ev[`DTP_EV_FALL]) // [R2]
        else $error("fall event lost");
    a_thr_event: assert property (above_now[0] != q.above[0] && !q.trip |=> q.ev[`DTP_EV_THR1]) // [R12]
        else $error("threshold event lost");
    a_irq_oos: assert property (q.ev[`DTP_EV_OOS] && q.ctrl[`DTP_CTRL_IE_OOS] && !q.trip |=> thermal_irq_o) // [R10]
        else $error("out-of-spec interrupt missing");

    c_trip: cover property ($rose(q.trip));
    c_ext_release: cover property ($fell(q.ext));
    c_ext_throttle: cover property ($rose(q.ext) ##[1:4] engine_active_o);
    c_force_mod: cover property (q.th == dtp_pkg::TH_DROP_MOD);
    c_irq: cover property ($rose(thermal_irq_o));
endmodule : dtp_thermal
`default_nettype wire

// file: testbench/dtp_platform.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// platform side: pull-up, monitor, supply
// ********************************
module dtp_platform #(
    parameter int OFF_CYC = 20
) (
    input  wire logic clk_i,
    input  wire logic vr_hot_i,
    input  wire logic oe_i,
    input  wire logic trip_n_i,
    output logic      pin_o,
    output logic      supply_good_o
);
    int cnt = 0;
    // pull-up wins unless either party pulls low
    assign pin_o = !(oe_i || vr_hot_i);
    // supply cut far inside the allowed span; restored once trip clears
    assign supply_good_o = trip_n_i || (cnt < OFF_CYC);
    always @(posedge clk_i) begin
        cnt <= trip_n_i ? 0 : cnt + 1;
    end
endmodule : dtp_platform
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtp_params.svh"
// ********************************
// thermal protection bench
// ********************************
module testbench;
    localparam logic [7:0] TJ  = 8'h5A;
    localparam logic [7:0] CAT = 8'h7D;
    localparam logic [7:0] CL  = TJ - 8'h14;
    logic        clk_i, rst_i, cyc, stb, we, ack, sleep, pkg_lp, vr_hot, pin, sg;
    logic        oe, trip_n, nc_trip_n, halt, nc_hot, eng, clk_en, drop, irq, hot_lvl;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, q;
    logic [7:0]  temp;
    logic [2:0]  cst;
    int          bad_count, tests_run;

    dtp_thermal #(.TJ_MAX(TJ), .CAT_TEMP(CAT), .MOD_HALF_CYC(2), .FORCE_WAIT(4), .OOS_WAIT(8)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .die_temp_i(temp),
        .core_state_i(cst), .sleep_state_i(sleep), .pkg_low_power_i(pkg_lp), .supply_good_i(sg),
        .thermal_hot_n_i(pin), .thermal_hot_n_o(hot_lvl), .thermal_hot_n_oe_o(oe), .nc_thermal_hot_o(nc_hot),
        .catastrophic_trip_n_o(trip_n), .nc_catastrophic_trip_n_o(nc_trip_n), .halt_clocks_o(halt),
        .engine_active_o(eng), .core_clk_en_o(clk_en), .perf_drop_o(drop), .thermal_irq_o(irq));
    dtp_platform #(.OFF_CYC(20)) plat_u (.clk_i(clk_i), .vr_hot_i(vr_hot), .oe_i(oe),
        .trip_n_i(trip_n), .pin_o(pin), .supply_good_o(sg));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // held until ack is sampled; a missing ack counts as a mismatch
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (n >= 16) bad_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic ones(input logic [31:0] exp);
        int n;
        n = 0;
        repeat (8) begin
            @(posedge clk_i);
            n += int'(clk_en === 1'b1);
        end
        chk(n, exp);
    endtask : ones
    task automatic do_reset;
        rst_i <= 1'b1;
        tick(10);
        rst_i <= 1'b0;
    endtask : do_reset
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic t_regs;
        chk({oe, trip_n, nc_trip_n, halt, eng, clk_en, drop, irq}, 8'h64);
        chk(hot_lvl, 1'b0);
        wb(1'b0, `DTP_OFS_CTRL, '0);
        chk(q, `DTP_CTRL_RST);
        wb(1'b1, `DTP_OFS_READOUT, 32'hFFFF);
        wb(1'b0, `DTP_OFS_READOUT, '0);
        chk(q, 32'h114);
        pkg_lp <= 1'b1;
        tick(2);
        wb(1'b0, `DTP_OFS_READOUT, '0);
        chk(q[8], 1'b0);
        pkg_lp <= 1'b0;
    endtask : t_regs
    task automatic t_hot;
        wb(1'b1, `DTP_OFS_CTRL, 32'h09);
        temp <= TJ;
        tick(8);
        chk({oe, nc_hot, eng, irq}, 4'hF);
        ones(4);
        wb(1'b0, `DTP_OFS_STATUS, '0);
        chk(q & 32'h411, 32'h411);
        wb(1'b0, `DTP_OFS_READOUT, '0);
        chk(q[7:0], 8'h00);
        temp <= TJ - 8'h03;
        tick(8);
        chk({oe, eng, clk_en}, 3'h1);
        wb(1'b0, `DTP_OFS_STATUS, '0);
        chk(q[1], 1'b1);
        wb(1'b1, `DTP_OFS_CTRL, 32'h03);
        temp <= TJ;
        tick(8);
        chk(drop, 1'b1);
        ones(8);
        wb(1'b1, `DTP_OFS_CTRL, 32'h07);
        tick(8);
        ones(4);
        temp <= CL;
        tick(8);
        chk({drop, eng}, 2'h0);
    endtask : t_hot
    task automatic t_ext;
        vr_hot <= 1'b1;
        tick(4);
        chk(eng, 1'b0);
        tick(4);
        chk({eng, drop, oe}, 3'h6);
        ones(8);
        wb(1'b0, `DTP_OFS_STATUS, '0);
        chk(q[`DTP_ST_EXT], 1'b1);
        wb(1'b1, `DTP_OFS_CTRL, 32'h01);
        tick(4);
        ones(4);
        vr_hot <= 1'b0;
        tick(8);
        chk(eng, 1'b0);
    endtask : t_ext
    task automatic t_sleep;
        sleep <= 1'b1;
        temp <= TJ;
        tick(8);
        chk(oe, 1'b0);
        sleep <= 1'b0;
        tick(8);
        chk(oe, 1'b1);
        sleep <= 1'b1;
        temp <= CL;
        tick(8);
        chk(oe, 1'b1);
        sleep <= 1'b0;
        tick(8);
        chk(oe, 1'b0);
        cst <= 3'h4;
        temp <= TJ;
        vr_hot <= 1'b1;
        tick(8);
        chk({oe, nc_hot}, 2'h1);
        wb(1'b0, `DTP_OFS_STATUS, '0);
        chk(q[`DTP_ST_EXT], 1'b0);
        vr_hot <= 1'b0;
        temp <= CL;
        cst <= 3'h0;
        tick(8);
    endtask : t_sleep
    task automatic t_thr;
        wb(1'b1, `DTP_OFS_THRESH, 32'h10);
        wb(1'b1, `DTP_OFS_CTRL, 32'h21);
        wb(1'b1, `DTP_OFS_STATUS, 32'h1F);
        chk(irq, 1'b0);
        temp <= TJ - 8'h0C;
        tick(6);
        chk(irq, 1'b1);
        wb(1'b0, `DTP_OFS_STATUS, '0);
        chk(q[`DTP_EV_THR1], 1'b1);
    endtask : t_thr
    // a core in its deepest state leaves the trip to the north complex
    task automatic t_trip;
        cst <= 3'h4;
        temp <= CAT;
        tick(6);
        chk({trip_n, nc_trip_n}, 2'h2);
        temp <= CL;
        cst <= 3'h0;
        do_reset();
        wb(1'b1, `DTP_OFS_CTRL, 32'h00);
        temp <= CAT;
        tick(6);
        chk({trip_n, nc_trip_n, halt}, 3'h1);
        tick(30);
        chk(sg, 1'b0);
        temp <= CL;
        do_reset();
    endtask : t_trip

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        bad_count++;
        results();
    end
    initial begin
        {rst_i, cyc, stb, we, sleep, pkg_lp, vr_hot} = 7'h40;
        adr = 4'h0;
        sel = 4'h0;
        wdat = 32'h0;
        temp = CL;
        cst = 3'h0;
        bad_count = 0;
        tests_run = 0;
        do_reset();
        t_regs();
        t_hot();
        t_ext();
        t_sleep();
        t_thr();
        t_trip();
        results();
    end
endmodule : testbench
`default_nettype wire
